// >>> rtl/stall_prevention_current_limit.sv
// stall prevention and current limit on the output frequency ramp
// Functional notes
// R01 - accel select 0: plain ramp, no limiting
// R02 - accel select 1: current slows the ramp
// R03 - accel select 2: fastest ramp current allows
// R04 - accel limit 0..200 percent, default 150
// R05 - accel limit 200 disables accel limiting
// R06 - over accel limit: hold frequency, else ramp
// R07 - above base frequency scale limit by base/freq
// R08 - decel select 0: no bus voltage protection
// R09 - decel select 1: stretch decel on high bus
// R10 - decel select 2: fastest decel bus allows
// R11 - decel select 3: braking resistor fast decel
// R12 - decel 2 refused in vector methods
// R13 - decel 3 refused with vector and resistor
// R14 - user sets decel 0 with braking resistor
// R15 - run select 0: no running limit
// R16 - run select 1: dip by decel one after 100ms
// R17 - run select 2: dip by decel two
// R18 - run limit 30..200 percent, default 160
// R19 - run limit 200 disables running limit
// R20 - dip while over, climb back when under
// R21 - bus threshold register decides decel stretching
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`include "stall_consts.svh"
module stall_prevention_current_limit #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power stage measurements
    input wire stall_pkg::meas_t meas,
    // frequency command and state
    output logic [15:0] out_freq,
    output stall_pkg::flags_t flags
);
    stall_pkg::ctrl_t ctrl;
    logic [7:0] acc_lim;
    logic [7:0] run_lim;
    logic [15:0] base_freq;
    logic [15:0] acc_step;
    logic [15:0] dec1_step;
    logic [15:0] dec2_step;
    logic [15:0] freq_ref;
    logic [15:0] bus_thr;
    stall_pkg::phase_t phase;
    stall_pkg::phase_t phase_w;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic tick;
    logic run_active;
    logic [6:0] run_cnt;

    tick_divider #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    // register read view, shared by reads and by byte-merged writes
    function automatic logic [31:0] reg_word(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `ADDR_CTRL: v[8:0] = ctrl;
            `ADDR_LIMIT: v[15:0] = {run_lim, acc_lim};
            `ADDR_BASE: v[15:0] = base_freq;
            `ADDR_ACC1: v[15:0] = acc_step;
            `ADDR_DEC1: v[15:0] = dec1_step;
            `ADDR_DEC2: v[15:0] = dec2_step;
            `ADDR_FREF: v[15:0] = freq_ref;
            `ADDR_BUSV: v[15:0] = bus_thr;
            `ADDR_STAT: v[6:0] = {phase, flags};
            `ADDR_FOUT: v[15:0] = out_freq;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_word

    // write decode
    logic do_write;
    logic [31:0] wmask;
    logic [31:0] new_word;
    stall_pkg::ctrl_t new_ctrl;
    logic vec_mode;
    logic ctrl_bad;
    logic lim_bad;
    logic hit_ctrl;
    logic hit_lim;
    logic hit_stat;
    logic mapped_w;
    logic wr_err;
    logic reject_set;
    logic reject_clr;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    // a process, not an assign: the merge must follow the registers read inside reg_word
    always_comb
    begin
        new_word = (reg_word(aw_addr) & ~wmask) | (w_data & wmask);
    end
    assign new_ctrl = stall_pkg::ctrl_t'(new_word[8:0]);
    assign vec_mode = (new_ctrl.drive_method_select == `METHOD_VEC_A)
                   || (new_ctrl.drive_method_select == `METHOD_VEC_B);
    assign ctrl_bad = vec_mode && ((new_ctrl.decel_stall_select == `SEL_SMART) // R12
        || (new_ctrl.decel_stall_select == `SEL_BRAKE && new_ctrl.brake_fitted)); // R13
    assign lim_bad = (new_word[7:0] > `LIM_OFF) // R04
        || (new_word[15:8] > `LIM_OFF) || (new_word[15:8] < `RUN_LIM_MIN); // R18
    assign hit_ctrl = aw_addr == `ADDR_CTRL;
    assign hit_lim = aw_addr == `ADDR_LIMIT;
    assign hit_stat = aw_addr == `ADDR_STAT;
    assign mapped_w = hit_ctrl || hit_lim || hit_stat || (aw_addr == `ADDR_BASE)
        || (aw_addr == `ADDR_ACC1) || (aw_addr == `ADDR_DEC1) || (aw_addr == `ADDR_DEC2)
        || (aw_addr == `ADDR_FREF) || (aw_addr == `ADDR_BUSV);
    assign reject_set = do_write && ((hit_ctrl && ctrl_bad) || (hit_lim && lim_bad));
    assign wr_err = !mapped_w || reject_set;
    assign reject_clr = do_write && hit_stat && w_strb[0] && w_data[0];

    // write channel: address and data accepted in either order
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (do_write)
            aw_held <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (do_write)
            w_held <= 1'b0;
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // rejected settings leave the old value in place
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl <= `CTRL_RST;
            acc_lim <= `ACC_LIM_RST; // R04
            run_lim <= `RUN_LIM_RST; // R18
        end
        else if (do_write && !wr_err)
        begin
            if (hit_ctrl)
                ctrl <= new_ctrl;
            if (hit_lim)
                {run_lim, acc_lim} <= new_word[15:0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            base_freq <= `BASE_RST;
            acc_step <= `STEP_RST;
            dec1_step <= `STEP_RST;
            dec2_step <= `STEP_RST;
            freq_ref <= 16'h0000;
            bus_thr <= `BUS_THR_RST;
        end
        else if (do_write)
        begin
            unique case (aw_addr)
                `ADDR_BASE: base_freq <= new_word[15:0];
                `ADDR_ACC1: acc_step <= new_word[15:0];
                `ADDR_DEC1: dec1_step <= new_word[15:0];
                `ADDR_DEC2: dec2_step <= new_word[15:0];
                `ADDR_FREF: freq_ref <= new_word[15:0];
                `ADDR_BUSV: bus_thr <= new_word[15:0];
                default: ;
            endcase
        end
    end

    // read channel
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= reg_word(s_axi_araddr);
            s_axi_rresp <= (s_axi_araddr > `ADDR_FOUT || s_axi_araddr[1:0] != 2'h0)
                ? `RESP_SLVERR : `RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // limit decisions
    logic [9:0] cur;
    logic [25:0] prod_cur;
    logic [23:0] prod_lim;
    logic over_acc;
    logic acc_en;
    logic acc_hold_w;
    logic [15:0] acc_rate;
    logic bus_high;
    logic dec_slow_w;
    logic [15:0] dec_rate;
    logic run_en;
    logic over_run;
    logic [15:0] run_rate;
    logic [15:0] goal;
    logic [15:0] step;
    logic [15:0] next_freq;

    assign cur = meas.motor_current;
    // cross-multiplied so the scaled limit needs no divider
    assign prod_cur = 26'(cur * out_freq);
    assign prod_lim = 24'(acc_lim * base_freq);
    assign over_acc = (out_freq > base_freq) ? (prod_cur > {2'b00, prod_lim}) // R07
                                             : (cur > {2'b00, acc_lim});
    assign acc_en = (ctrl.accel_stall_select != `SEL_OFF) && (acc_lim != `LIM_OFF); // R05
    assign acc_hold_w = acc_en && over_acc; // R02
    assign acc_rate = (ctrl.accel_stall_select == `SEL_SMART) ? `MAX_STEP : acc_step; // R03
    assign bus_high = meas.dc_bus_voltage > bus_thr; // R21
    assign dec_slow_w = (ctrl.decel_stall_select != `SEL_OFF) && bus_high;
    assign dec_rate =
        (ctrl.decel_stall_select == `SEL_OFF) ? dec1_step : // R08
        (ctrl.decel_stall_select == `SEL_NORMAL) ? (bus_high ? 16'h0000 : dec1_step) : // R09
        (ctrl.decel_stall_select == `SEL_SMART) ? (bus_high ? 16'h0000 : `MAX_STEP) : // R10
        (bus_high ? {1'b0, dec1_step[15:1]} : {dec1_step[14:0], 1'b0}); // R11
    assign run_en = (ctrl.run_stall_select != `SEL_OFF) && (run_lim != `LIM_OFF); // R15 R19
    assign over_run = cur > {2'b00, run_lim};
    assign run_rate = (ctrl.run_stall_select == `SEL_SMART) ? dec2_step : dec1_step; // R17

    assign phase_w = run_active ? (over_run ? stall_pkg::ph_run_dip
                                            : stall_pkg::ph_run_recover) // R20
                   : (out_freq < freq_ref) ? stall_pkg::ph_accel
                   : (out_freq > freq_ref) ? stall_pkg::ph_decel
                   : stall_pkg::ph_steady;

    always_comb
    begin
        goal = freq_ref;
        step = 16'h0000;
        unique case (phase_w)
            stall_pkg::ph_accel: step = acc_hold_w ? 16'h0000 : acc_rate; // R01 R06
            stall_pkg::ph_decel: step = dec_rate;
            stall_pkg::ph_run_dip:
            begin
                goal = 16'h0000;
                step = run_rate; // R16
            end
            stall_pkg::ph_run_recover: step = acc_step; // R20
            stall_pkg::ph_steady: step = 16'h0000;
        endcase
    end

    ramp_step u_step (
        .now(out_freq),
        .goal(goal),
        .step(step),
        .next_freq(next_freq)
    );

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            out_freq <= 16'h0000;
        else if (tick)
            out_freq <= next_freq;
    end

    // running limit: over limit at speed agree for the full delay
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            run_active <= 1'b0;
            run_cnt <= 7'h00;
        end
        else if (!run_en)
        begin
            run_active <= 1'b0; // R15 R19
            run_cnt <= 7'h00;
        end
        else if (tick)
        begin
            if (run_active)
                run_active <= over_run || (next_freq != freq_ref); // R20
            else if (out_freq == freq_ref && over_run)
            begin
                run_active <= run_cnt == 7'(`RUN_DELAY_TICKS); // R16
                run_cnt <= (run_cnt == 7'(`RUN_DELAY_TICKS)) ? 7'h00 : run_cnt + 7'h01;
            end
            else
                run_cnt <= 7'h00;
        end
    end

    // status; a reject in the same cycle as its clear stays set
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags <= '0;
            phase <= stall_pkg::ph_steady;
        end
        else
        begin
            flags.accel_hold <= (phase_w == stall_pkg::ph_accel) && acc_hold_w;
            flags.decel_stretch <= (phase_w == stall_pkg::ph_decel) && dec_slow_w;
            flags.run_limit <= run_active;
            flags.reject <= reject_set || (flags.reject && !reject_clr);
            phase <= phase_w;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence acc_tick_s;
        tick && (phase_w == stall_pkg::ph_accel);
    endsequence
    sequence dec_tick_s;
        tick && (phase_w == stall_pkg::ph_decel);
    endsequence

    accel_plain_a: assert property (acc_tick_s ##0 (ctrl.accel_stall_select == `SEL_OFF) // R01
        && acc_step != 16'h0000 |=> out_freq > $past(out_freq))
        else $error("accel select 0 did not raise frequency");
    accel_hold_a: assert property (acc_tick_s ##0 acc_en && over_acc // R06
        |=> out_freq == $past(out_freq))
        else $error("frequency moved while over the accel limit");
    limit_off_a: assert property (acc_tick_s ##0 acc_lim == `LIM_OFF // R05
        && acc_rate != 16'h0000 |=> out_freq > $past(out_freq))
        else $error("accel limit 200 still held the ramp");
    smart_acc_a: assert property (acc_tick_s ##0 !acc_hold_w // R03
        && (ctrl.accel_stall_select == `SEL_SMART) && (freq_ref - out_freq >= `MAX_STEP)
        |=> out_freq - $past(out_freq) == `MAX_STEP)
        else $error("intelligent accel step wrong");
    decel_hold_a: assert property (dec_tick_s ##0 bus_high // R09
        && ctrl.decel_stall_select == `SEL_NORMAL |=> $stable(out_freq))
        else $error("decel not stretched on high bus");
    decel_off_a: assert property (dec_tick_s ##0 ctrl.decel_stall_select == `SEL_OFF // R08
        && dec1_step != 16'h0000 |=> out_freq < $past(out_freq))
        else $error("decel select 0 did not lower frequency");
    vector_rej_a: assert property (do_write && hit_ctrl && ctrl_bad // R12
        |=> ctrl == $past(ctrl) ##0 flags.reject)
        else $error("illegal decel setting was taken");
    run_delay_a: assert property ($rose(run_active) // R16
        |-> $past(run_cnt) == 7'(`RUN_DELAY_TICKS))
        else $error("running limit began before the delay");
    run_dip_a: assert property (tick && run_active && over_run && run_rate != 16'h0000 // R20
        && out_freq != 16'h0000 |=> out_freq < $past(out_freq))
        else $error("frequency not lowered under running limit");
    run_off_a: assert property (!run_en |=> !run_active) // R19
        else $error("running limit active while disabled");
endmodule : stall_prevention_current_limit

// >>> rtl/stall_consts.svh
// register map, reset values and timing figures for the stall prevention block
`ifndef STALL_CONSTS_SVH
`define STALL_CONSTS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_LIMIT 8'h04
`define ADDR_BASE 8'h08
`define ADDR_ACC1 8'h0C
`define ADDR_DEC1 8'h10
`define ADDR_DEC2 8'h14
`define ADDR_FREF 8'h18
`define ADDR_BUSV 8'h1C
`define ADDR_STAT 8'h20
`define ADDR_FOUT 8'h24
`define SEL_OFF 2'h0
`define SEL_NORMAL 2'h1
`define SEL_SMART 2'h2
`define SEL_BRAKE 2'h3
`define METHOD_VEC_A 2'h2
`define METHOD_VEC_B 2'h3
`define LIM_OFF 8'hC8
`define ACC_LIM_RST 8'h96
`define RUN_LIM_RST 8'hA0
`define RUN_LIM_MIN 8'h1E
`define CTRL_RST 9'h015
`define STEP_RST 16'h0001
`define BASE_RST 16'h0600
`define BUS_THR_RST 16'h0300
`define MAX_STEP 16'h0100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_PERIOD_NS 20
`define TICK_NS 1000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_MS 1
`define RUN_DELAY_MS 100
`define RUN_DELAY_TICKS (`RUN_DELAY_MS / `TICK_MS)
`endif

// >>> rtl/stall_pkg.sv
// types shared by the stall prevention block
package stall_pkg;
    typedef struct packed {
        logic brake_fitted;
        logic [1:0] drive_method_select;
        logic [1:0] run_stall_select;
        logic [1:0] decel_stall_select;
        logic [1:0] accel_stall_select;
    } ctrl_t;
    typedef struct packed {
        logic [9:0] motor_current;
        logic [15:0] dc_bus_voltage;
    } meas_t;
    typedef struct packed {
        logic accel_hold;
        logic decel_stretch;
        logic run_limit;
        logic reject;
    } flags_t;
    typedef enum logic [2:0] {
        ph_steady,
        ph_accel,
        ph_decel,
        ph_run_dip,
        ph_run_recover
    } phase_t;
endpackage : stall_pkg

// >>> rtl/tick_divider.sv
// divides the control clock into a one-cycle ramp tick
module tick_divider #(
    parameter int unsigned DIV = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // tick
    output logic tick
);
    localparam int W = $clog2(DIV + 1);
    logic [W-1:0] count;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (count == W'(DIV - 1))
        begin
            count <= '0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : tick_divider

// >>> rtl/ramp_step.sv
// one saturating frequency step toward a goal
module ramp_step (
    // present frequency, goal and step size
    input wire logic [15:0] now,
    input wire logic [15:0] goal,
    input wire logic [15:0] step,
    // result
    output logic [15:0] next_freq
);
    logic [16:0] up_sum;
    logic [16:0] dn_diff;
    logic going_up;
    logic up_past;
    logic dn_past;

    assign up_sum = {1'b0, now} + {1'b0, step};
    assign dn_diff = {1'b0, now} - {1'b0, step};
    assign going_up = goal > now;
    // never step across the goal, never wrap below zero
    assign up_past = up_sum > {1'b0, goal};
    assign dn_past = dn_diff[16] || (dn_diff[15:0] < goal);
    assign next_freq = going_up ? (up_past ? goal : up_sum[15:0])
                                : (dn_past ? goal : dn_diff[15:0]);
endmodule : ramp_step

// >>> sim/power_stage_model.sv
// behavioural motor and power stage feeding current and bus voltage to the block
module power_stage_model #(
    parameter logic [15:0] BUS_NOM = 16'h0200,
    parameter logic [15:0] BUS_HIGH = 16'h0400
) (
    // clock
    input wire logic ref_clk,
    // bench controls
    input wire logic [9:0] load_pct,
    input wire logic regen,
    // measurements
    output stall_pkg::meas_t meas
);
    timeunit 1ns;
    timeprecision 1ps;
    // registered so measurements never move in the sampling time step
    always_ff @(posedge ref_clk)
    begin
        meas.motor_current <= load_pct;
        meas.dc_bus_voltage <= regen ? BUS_HIGH : BUS_NOM;
    end
endmodule : power_stage_model

// >>> sim/tb.sv
// self-checking bench for the stall prevention block
`include "stall_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    localparam int LIMIT = 20000;
    logic ref_clk;
    logic sys_rst;
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    stall_pkg::meas_t meas;
    logic [15:0] out_freq;
    stall_pkg::flags_t flags;
    logic [9:0] ld;
    logic rg;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int dl[4] = '{35, 35, 3, 19};
    stall_prevention_current_limit #(.TICK_CYCLES(TC)) stall_prevention_current_limit_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .meas(meas), .out_freq(out_freq), .flags(flags)
    );
    power_stage_model power_stage_model_i (
        .ref_clk(ref_clk), .load_pct(ld), .regen(rg), .meas(meas)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        chk("bresp", 32'(s_axi_bresp), 32'(e));
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic wt(input int t);
        repeat (t * TC) @(posedge ref_clk);
    endtask : wt
    // bounded wait for the command to land on a value, then compare
    task automatic wf(input logic [15:0] e, input int t);
        int n;
        n = 0;
        while (out_freq !== e && n < t * TC)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("out_freq", 32'(out_freq), 32'(e));
    endtask : wf
    task automatic up;
        rg <= 1'b0;
        ld <= 10'h064;
        wr(`ADDR_CTRL, 32'h0000_0002);
        wr(`ADDR_FREF, 32'h0000_0040);
        wf(16'h0040, 3);
    endtask : up
    task automatic down;
        wr(`ADDR_FREF, 32'h0000_0000);
        wf(16'h0000, 40);
    endtask : down
    initial
    begin
        sys_rst = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        ld = 10'h064;
        rg = 1'b0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(`ADDR_CTRL, 32'h0000_0015);
        rd(`ADDR_LIMIT, 32'h0000_A096);
        rd(8'h28, 32'h0000_0000, `RESP_SLVERR);
        wr(`ADDR_FOUT, 32'h0000_0001, `RESP_SLVERR);
        wr(`ADDR_LIMIT, 32'h0000_A0C9, `RESP_SLVERR);
        wr(`ADDR_LIMIT, 32'h0000_1D96, `RESP_SLVERR);
        wr(`ADDR_LIMIT, 32'h0000_1E00);
        wr(`ADDR_LIMIT, 32'h0000_A096);
        wr(`ADDR_STAT, 32'h0000_0001);
        wr(`ADDR_CTRL, 32'h0000_0099, `RESP_SLVERR);
        chk("reject", 32'(flags.reject), 32'h0000_0001);
        rd(`ADDR_CTRL, 32'h0000_0015);
        wr(`ADDR_CTRL, 32'h0000_01DD, `RESP_SLVERR);
        wr(`ADDR_CTRL, 32'h0000_0019);
        wr(`ADDR_CTRL, 32'h0000_0111);
        wr(`ADDR_STAT, 32'h0000_0001);
        chk("reject", 32'(flags.reject), 32'h0000_0000);
        wr(`ADDR_ACC1, 32'h0000_0001);
        wr(`ADDR_DEC1, 32'h0000_0002);
        wr(`ADDR_DEC2, 32'h0000_0008);
        // plain ramp ignores current; running limit off
        ld <= 10'h0AA;
        wr(`ADDR_CTRL, 32'h0000_0000);
        wr(`ADDR_FREF, 32'h0000_0040);
        wf(16'h0040, 70);
        wt(110);
        chk("run_limit", 32'(flags.run_limit), 32'h0000_0000);
        down();
        wr(`ADDR_CTRL, 32'h0000_0001);
        wr(`ADDR_FREF, 32'h0000_0040);
        wt(20);
        chk("out_freq", 32'(out_freq), 32'h0000_0000);
        chk("accel_hold", 32'(flags.accel_hold), 32'h0000_0001);
        ld <= 10'h064;
        wf(16'h0040, 70);
        down();
        up();
        chk("out_freq", 32'(out_freq), 32'h0000_0040);
        down();
        wr(`ADDR_LIMIT, 32'h0000_A0C8);
        wr(`ADDR_CTRL, 32'h0000_0001);
        ld <= 10'h0C7;
        wr(`ADDR_FREF, 32'h0000_0040);
        wf(16'h0040, 70);
        wr(`ADDR_LIMIT, 32'h0000_A096);
        down();
        // 120 * f > 150 * 16 first holds at f = 0x15
        wr(`ADDR_BASE, 32'h0000_0010);
        ld <= 10'h078;
        wr(`ADDR_FREF, 32'h0000_0040);
        wf(16'h0015, 30);
        wt(10);
        chk("out_freq", 32'(out_freq), 32'h0000_0015);
        down();
        wr(`ADDR_BASE, 32'h0000_0600);
        for (int s = 0; s < 4; s++)
        begin
            up();
            rg <= (s < 2);
            wr(`ADDR_CTRL, 32'(s * 4 + 2));
            wr(`ADDR_FREF, 32'h0000_0000);
            if (s == 1)
            begin
                wt(10);
                chk("out_freq", 32'(out_freq), 32'h0000_0040);
                chk("decel_stretch", 32'(flags.decel_stretch), 32'h0000_0001);
                rg <= 1'b0;
            end
            wf(16'h0000, dl[s]);
        end
        for (int s = 1; s < 4; s++)
        begin
            up();
            if (s == 3)
                wr(`ADDR_LIMIT, 32'h0000_C896);
            wr(`ADDR_CTRL, (s == 3) ? 32'h0000_0012 : 32'(s * 16 + 2));
            ld <= 10'h0AA;
            wt(95);
            chk("run_limit", 32'(flags.run_limit), 32'h0000_0000);
            if (s == 3)
            begin
                wt(15);
                chk("run_limit", 32'(flags.run_limit), 32'h0000_0000);
                chk("out_freq", 32'(out_freq), 32'h0000_0040);
                wr(`ADDR_LIMIT, 32'h0000_A096);
            end
            else
            begin
                wf(16'h0030, (s == 1) ? 18 : 12);
                chk("run_limit", 32'(flags.run_limit), 32'h0000_0001);
                ld <= 10'h064;
                wf(16'h0040, 40);
                wt(2);
                chk("run_limit", 32'(flags.run_limit), 32'h0000_0000);
            end
            down();
        end
        stop_test();
    end
endmodule : tb
